// file: logic/asq_pkg.sv
// Purpose: Shared constants and types for the sequencing converter control
// Assumes: System clock of 100 MHz
// Notes: Timing counts are derived from times in nanoseconds
package asq_pkg;

    localparam int SYS_CLK_MHZ = 100;
    localparam int ACQ_TIME_NS = 600;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int QUIET_TIME_NS = 200;
    localparam int QUIET_CYCLES = (QUIET_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int FILTER_TIME_NS = 50;
    localparam int FILTER_CYCLES = (FILTER_TIME_NS * SYS_CLK_MHZ + 999) / 1000;

    localparam logic [7:0] SETUP_RESET = 8'hF0;
    localparam int SETUP_EN_LSB = 4;
    localparam int SETUP_REF_BIT = 3;
    localparam int SETUP_LINE_FILTER_BYPASS_BIT = 2;
    localparam int SETUP_TRIAL_BIT = 1;
    localparam int SETUP_SAMPLE_BIT = 0;

    localparam int DATA_W = 12;
    localparam int RES_BITS_DEFAULT = 12;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // Arbitrary neutral address value
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
    localparam logic [1:0] LAST_CHANNEL = 2'h3;

    typedef struct packed {
        logic [3:0] input_enable_bits;
        logic ref_external;
        logic line_filter_bypass;
        logic trial_delay_off;
        logic sample_delay_off;
    } asq_setup_t;

    typedef struct packed {
        logic [1:0] lead_zero;
        logic result_tag_high;
        logic result_tag_low;
        logic [DATA_W-1:0] data;
    } asq_result_t;

    typedef enum logic [1:0] {LK_ADDR, LK_WRITE, LK_READ, LK_IGNORE} asq_link_state_t;
    typedef enum logic [1:0] {CV_IDLE, CV_ACQ, CV_SAMPLE, CV_TRIAL} asq_conv_state_t;
    typedef enum logic [1:0] {SAR_IDLE, SAR_SETTLE, SAR_DECIDE} asq_sar_state_t;

endpackage

// file: logic/asq_seq.sv
// Purpose: Picks the next enabled input in ascending order
// Assumes: Enables already masked for the reference input
// Notes: Purely combinational
`timescale 1ns/10ps
module asq_seq (
    input wire logic [3:0] enables,
    input wire logic [1:0] last_ch,
    input wire logic restart,
    output logic [1:0] next_ch,
    output logic any_enabled
);

    function automatic logic [1:0] pick_after(input logic [3:0] en, input logic [1:0] cur);
        logic [1:0] cand;
        logic found;
        pick_after = cur;
        found = 1'b0;
        for (int i = 1; i <= 4; i++) begin
            cand = 2'(cur + 2'(i));
            if (!found && en[cand]) begin
                pick_after = cand;
                found = 1'b1;
            end
        end
    endfunction

    // Restart from the top channel so the search lands on the lowest one
    always_comb begin
        if (restart) begin
            next_ch = pick_after(enables, asq_pkg::LAST_CHANNEL); // RULE2
        end else begin
            next_ch = pick_after(enables, last_ch); // RULE3
        end
        any_enabled = |enables;
    end

endmodule

// file: logic/asq_sar.sv
// Purpose: Successive approximation bit trial sequencing
// Assumes: Comparator output settles within one clock after a trial code
// Notes: Trials may wait for a quiet bus
`timescale 1ns/10ps
module asq_sar #(
    parameter int RES_BITS = asq_pkg::RES_BITS_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic trial_wait_en,
    input wire logic bus_quiet,
    input wire logic comp_in,
    output logic [RES_BITS-1:0] dac_code,
    output logic done
);

    asq_pkg::asq_sar_state_t state;
    logic [RES_BITS-1:0] mask;
    logic [RES_BITS-1:0] kept;
    logic decide_now;

    assign decide_now = (state == asq_pkg::SAR_DECIDE) && (!trial_wait_en || bus_quiet);
    // Comparator high means input is above the trial level
    assign kept = comp_in ? dac_code : (dac_code & ~mask);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= asq_pkg::SAR_IDLE;
            mask <= '0;
            dac_code <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                asq_pkg::SAR_IDLE: begin
                    if (start) begin
                        mask <= {1'b1, {(RES_BITS-1){1'b0}}};
                        dac_code <= {1'b1, {(RES_BITS-1){1'b0}}};
                        state <= asq_pkg::SAR_SETTLE;
                    end
                end
                asq_pkg::SAR_SETTLE: begin
                    state <= asq_pkg::SAR_DECIDE;
                end
                asq_pkg::SAR_DECIDE: begin
                    if (decide_now) begin // RULE9
                        dac_code <= kept | (mask >> 1);
                        mask <= mask >> 1;
                        if (mask[0]) begin
                            done <= 1'b1;
                            state <= asq_pkg::SAR_IDLE;
                        end else begin
                            state <= asq_pkg::SAR_SETTLE;
                        end
                    end
                end
                default: begin
                    state <= asq_pkg::SAR_IDLE;
                end
            endcase
        end
    end

endmodule

// file: logic/asq_ctrl.sv
// Purpose: Two-wire slave, setup register, channel sequencer and conversion control
// Assumes: SCL low and high phases each last at least 100 ns
// Notes: A read returns the most recent finished result
`timescale 1ns/10ps
// How it works
// RULE1: Setup bits enable their analog inputs
// RULE2: Several enabled inputs are stepped, lowest first
// RULE3: Bit four is input zero, ascending order
// RULE4: Host enables an input before converting
// RULE5: Reference bit swaps input three for reference
// RULE6: Filter bit zero keeps line filtering on
// RULE7: Delay bits zero enable both delays
// RULE8: Delay bits one disable both delays
// RULE9: Sampling and trials wait for quiet bus
// RULE10: Host should stretch clock, avoid bus traffic
// RULE11: Result is sixteen bit straight binary word
// RULE12: Two zeros, channel tag, then data
// RULE13: Narrow variants pad low bits with zeros
// RULE14: Device answers one seven bit address
// RULE15: Host opens transfers with start condition
// RULE16: Eight bits shifted, address then direction
// RULE17: Matching address acknowledged before ninth pulse
// RULE18: Direction zero writes, one reads
// RULE19: Nine pulses per byte, data moves low
// RULE20: Host ends write with stop
// RULE21: Host ends read with no acknowledge, stop
// RULE22: One direction per transfer
// RULE23: First written byte loads setup register
// RULE24: Reset setup enables all four inputs
// RULE25: Read acknowledge starts the next conversion
// RULE26: External reference removes input three from sequence
module asq_ctrl #(
    parameter logic [6:0] DEV_ADDR = asq_pkg::DEV_ADDR_DEFAULT,
    parameter int RES_BITS = asq_pkg::RES_BITS_DEFAULT
) (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic COMP_IN,
    output logic [RES_BITS-1:0] DAC_CODE,
    output logic [3:0] ANALOG_INPUT_SELECT,
    output logic TRACK,
    output logic POWER_UP,
    output logic REF_EXTERNAL,
    output logic LINE_FILTER_BYPASS
);

    logic [1:0] rst_ff;
    logic rst_n;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_lvl;
    logic sda_lvl;
    logic scl_f;
    logic sda_f;
    logic scl_d;
    logic sda_d;
    logic [7:0] flt_cnt;
    logic [7:0] quiet_cnt;
    logic bus_quiet;
    logic start_cond;
    logic stop_cond;
    logic link_armed;
    logic link_rst_n;
    asq_pkg::asq_link_state_t link_state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic first_byte;
    logic byte_hi;
    logic [15:0] rdword;
    logic addr_hit;
    logic take_req;
    logic take_cfg;
    logic req_tgl;
    logic cfg_tgl;
    logic [7:0] cfg_shadow;
    logic next_oe;
    logic [2:0] req_sync;
    logic [2:0] cfg_sync;
    logic req_seen;
    logic cfg_seen;
    logic req_evt;
    logic cfg_evt;
    asq_pkg::asq_setup_t setup;
    asq_pkg::asq_result_t result;
    asq_pkg::asq_conv_state_t cv_state;
    logic pending;
    logic take_conv;
    logic [1:0] last_ch;
    logic [1:0] cur_ch;
    logic seq_restart;
    logic [3:0] eff_en;
    logic [1:0] next_ch;
    logic any_enabled;
    logic [7:0] acq_cnt;
    logic sar_start;
    logic sar_done;
    logic [RES_BITS-1:0] sar_code;
    logic [asq_pkg::DATA_W-1:0] data_aligned;

    // Reset release through two flops
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rst_ff <= 2'h0;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_ff[1];

    // Pins pass three flops; a change counts once the last two agree
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_lvl <= 1'b1;
            sda_lvl <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], SCL};
            sda_sync <= {sda_sync[1:0], SDA_IN};
            if (scl_sync[1] == scl_sync[2]) begin
                scl_lvl <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                sda_lvl <= sda_sync[2];
            end
        end
    end

    // Glitch filter: a change must persist before it is believed
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            flt_cnt <= 8'h00;
        end else if (setup.line_filter_bypass) begin // RULE6
            scl_f <= scl_lvl;
            sda_f <= sda_lvl;
            flt_cnt <= 8'h00;
        end else if ({scl_lvl, sda_lvl} == {scl_f, sda_f}) begin
            flt_cnt <= 8'h00;
        end else if (flt_cnt == 8'(asq_pkg::FILTER_CYCLES - 1)) begin // RULE6
            scl_f <= scl_lvl;
            sda_f <= sda_lvl;
            flt_cnt <= 8'h00;
        end else begin
            flt_cnt <= flt_cnt + 8'h01;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    assign start_cond = scl_f && scl_d && sda_d && !sda_f; // RULE15
    assign stop_cond = scl_f && scl_d && !sda_d && sda_f; // RULE20 RULE21

    // Bus is quiet once neither line has moved for a while
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            quiet_cnt <= 8'h00;
        end else if ((scl_f != scl_d) || (sda_f != sda_d)) begin
            quiet_cnt <= 8'h00;
        end else if (quiet_cnt != 8'(asq_pkg::QUIET_CYCLES)) begin
            quiet_cnt <= quiet_cnt + 8'h01;
        end
    end
    assign bus_quiet = (quiet_cnt == 8'(asq_pkg::QUIET_CYCLES));

    // Link logic is held in reset between frames and freed at the first SCL fall
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            link_armed <= 1'b0;
            link_rst_n <= 1'b0;
        end else if (start_cond) begin
            link_armed <= 1'b1;
            link_rst_n <= 1'b0;
        end else if (stop_cond) begin
            link_armed <= 1'b0;
            link_rst_n <= 1'b0;
        end else if (link_armed && scl_d && !scl_f) begin
            link_rst_n <= 1'b1;
        end
    end

    assign addr_hit = (shreg[7:1] == DEV_ADDR); // RULE14
    assign take_req = ((link_state == asq_pkg::LK_ADDR) && addr_hit && shreg[0])
        || ((link_state == asq_pkg::LK_READ) && !byte_hi && !SDA_IN);
    assign take_cfg = (link_state == asq_pkg::LK_WRITE) && first_byte;

    // Byte engine on the link clock; nine pulses per byte
    always_ff @(posedge SCL or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_state <= asq_pkg::LK_ADDR;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            first_byte <= 1'b1;
            byte_hi <= 1'b1;
            rdword <= 16'h0000;
        end else if (bit_cnt != asq_pkg::ACK_SLOT) begin
            shreg <= {shreg[6:0], SDA_IN}; // RULE16 RULE19
            bit_cnt <= bit_cnt + 4'h1;
        end else begin
            bit_cnt <= 4'h0;
            case (link_state)
                asq_pkg::LK_ADDR: begin
                    if (!addr_hit) begin
                        link_state <= asq_pkg::LK_IGNORE; // RULE17
                    end else if (shreg[0]) begin
                        link_state <= asq_pkg::LK_READ; // RULE18
                        rdword <= result;
                        byte_hi <= 1'b1;
                    end else begin
                        link_state <= asq_pkg::LK_WRITE; // RULE18
                    end
                end
                asq_pkg::LK_WRITE: begin
                    first_byte <= 1'b0; // RULE23
                end
                asq_pkg::LK_READ: begin
                    if (SDA_IN) begin
                        link_state <= asq_pkg::LK_IGNORE; // RULE21
                    end else if (byte_hi) begin
                        byte_hi <= 1'b0;
                    end else begin
                        // Previous result; the new conversion runs during readout
                        rdword <= result; // RULE11
                        byte_hi <= 1'b1;
                    end
                end
                default: begin
                    link_state <= asq_pkg::LK_IGNORE; // RULE22
                end
            endcase
        end
    end

    // Events toward the system side travel as toggles
    always_ff @(posedge SCL or negedge rst_n) begin
        if (!rst_n) begin
            req_tgl <= 1'b0;
            cfg_tgl <= 1'b0;
            cfg_shadow <= asq_pkg::SETUP_RESET;
        end else if (link_rst_n && (bit_cnt == asq_pkg::ACK_SLOT)) begin
            if (take_req) begin
                req_tgl <= ~req_tgl; // RULE25
            end
            if (take_cfg) begin
                cfg_shadow <= shreg; // RULE23
                cfg_tgl <= ~cfg_tgl;
            end
        end
    end

    // Data line changes on the falling edge, only while the clock is low
    always_comb begin
        next_oe = 1'b0;
        if (bit_cnt == asq_pkg::ACK_SLOT) begin
            case (link_state)
                asq_pkg::LK_ADDR: next_oe = addr_hit; // RULE17
                asq_pkg::LK_WRITE: next_oe = first_byte;
                default: next_oe = 1'b0;
            endcase
        end else if (link_state == asq_pkg::LK_READ) begin
            next_oe = byte_hi ? !rdword[4'hF - bit_cnt] : !rdword[4'h7 - bit_cnt]; // RULE19
        end
    end

    always_ff @(negedge SCL or negedge link_rst_n) begin
        if (!link_rst_n) begin
            SDA_OE <= 1'b0;
        end else begin
            SDA_OE <= next_oe;
        end
    end
    assign SDA_OUT = 1'b0;

    // Toggles cross with three flops each
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            req_sync <= 3'h0;
            cfg_sync <= 3'h0;
            req_seen <= 1'b0;
            cfg_seen <= 1'b0;
        end else begin
            req_sync <= {req_sync[1:0], req_tgl};
            cfg_sync <= {cfg_sync[1:0], cfg_tgl};
            if (req_evt) begin
                req_seen <= req_sync[2];
            end
            if (cfg_evt) begin
                cfg_seen <= cfg_sync[2];
            end
        end
    end
    assign req_evt = (req_sync[1] == req_sync[2]) && (req_sync[2] != req_seen);
    assign cfg_evt = (cfg_sync[1] == cfg_sync[2]) && (cfg_sync[2] != cfg_seen);

    // Shadow is stable once its toggle has crossed
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            setup <= asq_pkg::asq_setup_t'(asq_pkg::SETUP_RESET); // RULE24
        end else if (cfg_evt) begin
            setup <= asq_pkg::asq_setup_t'(cfg_shadow); // RULE1
        end
    end
    assign REF_EXTERNAL = setup.ref_external; // RULE5
    assign LINE_FILTER_BYPASS = setup.line_filter_bypass;
    assign eff_en = setup.input_enable_bits & {!setup.ref_external, 3'h7}; // RULE26 RULE3

    asq_seq u_seq (
        .enables(eff_en),
        .last_ch(last_ch),
        .restart(seq_restart),
        .next_ch(next_ch),
        .any_enabled(any_enabled)
    );

    // Request arriving with the take still counts
    assign take_conv = (cv_state == asq_pkg::CV_IDLE) && pending;
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else if (req_evt) begin
            pending <= 1'b1;
        end else if (take_conv) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            last_ch <= asq_pkg::LAST_CHANNEL;
            seq_restart <= 1'b1;
        end else if (cfg_evt) begin
            seq_restart <= 1'b1; // RULE2
        end else if (take_conv && any_enabled) begin
            last_ch <= next_ch; // RULE2
            seq_restart <= 1'b0;
        end
    end

    // No enabled input means the request is dropped
    assign sar_start = (cv_state == asq_pkg::CV_SAMPLE)
        && (setup.sample_delay_off || bus_quiet); // RULE7 RULE8 RULE9
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            cv_state <= asq_pkg::CV_IDLE;
            acq_cnt <= 8'h00;
            cur_ch <= 2'h0;
            POWER_UP <= 1'b0;
            TRACK <= 1'b0;
        end else begin
            case (cv_state)
                asq_pkg::CV_IDLE: begin
                    if (take_conv && any_enabled) begin // RULE4
                        cur_ch <= next_ch;
                        acq_cnt <= 8'h00;
                        POWER_UP <= 1'b1; // RULE25
                        TRACK <= 1'b1;
                        cv_state <= asq_pkg::CV_ACQ;
                    end
                end
                asq_pkg::CV_ACQ: begin
                    acq_cnt <= acq_cnt + 8'h01;
                    if (acq_cnt == 8'(asq_pkg::ACQ_CYCLES - 1)) begin
                        cv_state <= asq_pkg::CV_SAMPLE;
                    end
                end
                asq_pkg::CV_SAMPLE: begin
                    if (sar_start) begin
                        TRACK <= 1'b0;
                        cv_state <= asq_pkg::CV_TRIAL;
                    end
                end
                asq_pkg::CV_TRIAL: begin
                    if (sar_done) begin
                        POWER_UP <= 1'b0;
                        cv_state <= asq_pkg::CV_IDLE;
                    end
                end
                default: begin
                    cv_state <= asq_pkg::CV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            ANALOG_INPUT_SELECT <= 4'h0;
        end else begin
            ANALOG_INPUT_SELECT <= POWER_UP ? (4'h1 << cur_ch) : 4'h0;
        end
    end

    asq_sar #(
        .RES_BITS(RES_BITS)
    ) u_sar (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .start(sar_start),
        .trial_wait_en(!setup.trial_delay_off), // RULE7 RULE8
        .bus_quiet(bus_quiet),
        .comp_in(COMP_IN),
        .dac_code(sar_code),
        .done(sar_done)
    );
    assign DAC_CODE = sar_code;

    // Narrow variants sit high with zero padding below
    always_comb begin
        data_aligned = '0;
        data_aligned[asq_pkg::DATA_W-1 -: RES_BITS] = sar_code; // RULE13
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            result <= '0;
        end else if (sar_done) begin
            result.lead_zero <= 2'h0; // RULE12
            result.result_tag_high <= cur_ch[1];
            result.result_tag_low <= cur_ch[0];
            result.data <= data_aligned; // RULE11
        end
    end

endmodule

// file: test/asq_checker.sv
// Purpose: Port-level assertions for the converter control
// Assumes: Sees only the top ports, one system clock domain
// Notes: SCL and data are sampled as plain data here
`timescale 1ns/10ps
module asq_checker #(
    parameter int RES_BITS = 12
) (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic SCL,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic COMP_IN,
    input wire logic [RES_BITS-1:0] DAC_CODE,
    input wire logic [3:0] ANALOG_INPUT_SELECT,
    input wire logic TRACK,
    input wire logic POWER_UP,
    input wire logic REF_EXTERNAL,
    input wire logic LINE_FILTER_BYPASS
);
    logic [9:0] trk_cnt;
    // Length of the current acquisition
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            trk_cnt <= 10'h000;
        end else begin
            trk_cnt <= TRACK ? trk_cnt + 10'h001 : 10'h000;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    sda_zero_a: assert property (SDA_OUT == 1'b0)
        else $error("data pin value not zero");
    oe_low_a: assert property ($changed(SDA_OE) |-> !SCL)
        else $error("data line moved while clock high");
    sel_hot_a: assert property ($onehot0(ANALOG_INPUT_SELECT))
        else $error("more than one input selected");
    ref_skip_a: assert property (REF_EXTERNAL |-> !ANALOG_INPUT_SELECT[3])
        else $error("reference input converted");
    track_pwr_a: assert property (TRACK |-> POWER_UP)
        else $error("tracking while powered down");
    pwr_start_a: assert property ($rose(POWER_UP) |-> SCL && TRACK)
        else $error("power up not at clock high with tracking");
    acq_len_a: assert property ($fell(TRACK) |-> trk_cnt >= 10'(asq_pkg::ACQ_CYCLES - 1))
        else $error("acquisition too short");
    pwr_len_a: assert property ($rose(POWER_UP) |-> ##[1:1000] !POWER_UP)
        else $error("conversion never finished");
    cover property ($rose(POWER_UP));
    cover property ($rose(SDA_OE));
    cover property ($rose(REF_EXTERNAL));
endmodule

// file: test/asq_host.sv
// Purpose: Two-wire bus master model
// Assumes: Phases of 25 system clocks suit the slave
// Notes: SCL stands high outside frames; slow phases leave quiet gaps
`timescale 1ns/10ps
module asq_host (
    input wire logic clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    localparam int PH = 25;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hold();
        repeat (PH) @(posedge clk);
    endtask
    task automatic start();
        @(posedge clk);
        sda_low <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda_low <= 1'b1;
        hold();
        scl <= 1'b0;
    endtask
    task automatic stop();
        @(posedge clk);
        sda_low <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_low <= 1'b0;
        hold();
    endtask
    task automatic slot(input logic b, output logic got);
        @(posedge clk);
        sda_low <= !b;
        hold();
        scl <= 1'b1;
        hold();
        got = sda;
        scl <= 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] q,
                           output logic a);
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], q[i]);
        end
        slot(m, a);
    endtask
endmodule

// file: test/tb.sv
// Purpose: Self-checking bench for the converter control
// Assumes: Comparator model answers one clock after a trial code
// Notes: Read data trails the request by one conversion
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
    localparam logic [6:0] ADDR = asq_pkg::DEV_ADDR_DEFAULT;
    logic CLK_SYS = 1'b0;
    logic NRST = 1'b0;
    logic COMP_IN = 1'b0;
    logic SCL;
    logic h_low;
    logic SDA_OUT;
    logic SDA_OE;
    logic TRACK;
    logic POWER_UP;
    logic REF_EXTERNAL;
    logic LINE_FILTER_BYPASS;
    logic [11:0] DAC_CODE;
    logic [3:0] ANALOG_INPUT_SELECT;
    logic [11:0] lvl [4] = '{12'h0F1, 12'h5A3, 12'h9C7, 12'hE2B};
    logic [15:0] exp_q [$];
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    wire SDA_IN;
    // Open drain with pull-up
    assign SDA_IN = ~(SDA_OE | h_low);
    always #5 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        COMP_IN <= lvl[{ANALOG_INPUT_SELECT[3] | ANALOG_INPUT_SELECT[2],
                        ANALOG_INPUT_SELECT[3] | ANALOG_INPUT_SELECT[1]}] >= DAC_CODE;
    end
    asq_ctrl u_dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .SCL(SCL), .SDA_IN(SDA_IN),
        .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .COMP_IN(COMP_IN), .DAC_CODE(DAC_CODE),
        .ANALOG_INPUT_SELECT(ANALOG_INPUT_SELECT), .TRACK(TRACK), .POWER_UP(POWER_UP),
        .REF_EXTERNAL(REF_EXTERNAL), .LINE_FILTER_BYPASS(LINE_FILTER_BYPASS));
    asq_host u_host (.clk(CLK_SYS), .scl(SCL), .sda_low(h_low), .sda(SDA_IN));
    function automatic logic [15:0] w(input logic [1:0] ch);
        return {2'b00, ch, lvl[ch]};
    endfunction
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] d);
        logic [7:0] q;
        logic a;
        u_host.start();
        u_host.byte_io({ADDR, 1'b0}, 1'b1, q, a);
        `CHK("write address ack", 1'b0, a)
        u_host.byte_io(d, 1'b1, q, a);
        `CHK("setup byte ack", 1'b0, a)
        u_host.byte_io(8'h00, 1'b1, q, a);
        `CHK("extra byte ack", 1'b1, a)
        u_host.stop();
        repeat (20) @(posedge CLK_SYS);
    endtask
    task automatic rd(input int n, input logic [6:0] adr);
        logic [7:0] hi;
        logic [7:0] lo;
        logic [15:0] e;
        logic a;
        u_host.start();
        u_host.byte_io({adr, 1'b1}, 1'b1, hi, a);
        `CHK("read address ack", adr != ADDR, a)
        for (int i = 0; i < n; i++) begin
            u_host.byte_io(8'hFF, 1'b0, hi, a);
            u_host.byte_io(8'hFF, 1'(i == n - 1), lo, a);
            e = exp_q.pop_front();
            `CHK("result word", e, {hi, lo})
        end
        u_host.stop();
    endtask
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge CLK_SYS);
        NRST <= 1'b1;
        repeat (10) @(posedge CLK_SYS);
        `CHK("reference select", 1'b0, REF_EXTERNAL)
        `CHK("filter bypass", 1'b0, LINE_FILTER_BYPASS)
        exp_q = '{16'h0000, w(0), w(1), w(2), w(3)};
        rd(5, ADDR);
        rd(0, ADDR ^ 7'h01);
        $display("test reset and sequence done");
        wr(8'hAB);
        `CHK("reference select", 1'b1, REF_EXTERNAL)
        exp_q = '{w(0), w(1), w(1)};
        rd(3, ADDR);
        $display("test external reference done");
        wr(8'h54);
        `CHK("filter bypass", 1'b1, LINE_FILTER_BYPASS)
        `CHK("reference select", 1'b0, REF_EXTERNAL)
        exp_q = '{w(1), w(0), w(2), w(0)};
        rd(4, ADDR);
        $display("test two inputs done");
        report_and_stop();
    end
endmodule
bind asq_ctrl asq_checker #(.RES_BITS(RES_BITS)) u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST),
    .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .COMP_IN(COMP_IN),
    .DAC_CODE(DAC_CODE), .ANALOG_INPUT_SELECT(ANALOG_INPUT_SELECT), .TRACK(TRACK),
    .POWER_UP(POWER_UP), .REF_EXTERNAL(REF_EXTERNAL),
    .LINE_FILTER_BYPASS(LINE_FILTER_BYPASS));
